// ---- rtl/pio_port.sv ----
// strobe, flag and priority logic of the parallel i/o port
`timescale 1ns/1ps
`include "pio_consts.svh"
module pio_port #(
  parameter logic [`PIO_VEC_W-1:0] VECTOR_BASE = `PIO_VEC_BASE_DEF
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_resetn,
  input  wire logic                     i_io_strobe_n,
  input  wire logic                     i_first_transfer_phase,
  input  wire logic                     i_transfer_timing_phase,
  input  wire logic                     i_priority_enable_in,
  input  wire logic                     i_interrupt_grant_in,
  input  wire logic [`PIO_SENSE_W-1:0]  i_sense,
  input  wire logic [`PIO_ID_W-1:0]     i_select_id,
  input  wire logic [`PIO_BUS_W-1:0]    i_shared_bus,
  output logic [`PIO_BUS_W-1:0]         o_shared_bus_out,
  output logic                          o_shared_bus_oe,
  output logic [`PIO_SENSE_W-1:0]       o_flag,
  output logic                          o_read_strobe_one,
  output logic                          o_read_strobe_two,
  output logic                          o_read_strobe_three,
  output logic                          o_write_strobe_one,
  output logic                          o_write_strobe_two,
  output logic                          o_transfer_type_line_one_oe,
  output logic                          o_transfer_type_line_two_oe,
  output logic                          o_skip_or_irq_line_oe,
  output logic                          o_priority_chain_out
);
  pio_pkg::pio_pins_t  s;
  pio_pkg::pio_state_t r;
  pio_pkg::pio_state_t n;
  logic                phase_rise;
  logic                strobe_fall;
  logic                strobe_rise;
  logic [1:0]          vec_idx;

  // lowest numbered pending sense wins inside this element
  function automatic logic [1:0] first_idx(input logic [`PIO_SENSE_W-1:0] v);
    logic [1:0] idx;
    idx = 2'h0;
    for (int k = `PIO_SENSE_W - 1; k >= 0; k--) begin
      if (v[k]) begin
        idx = 2'(k);
      end
    end
    return idx;
  endfunction

  // commands that pull line one low in the first phase
  function automatic logic is_read_kind(input logic [`PIO_CMD_W-1:0] c);
    return (c == `PIO_CMD_RD1) || (c == `PIO_CMD_RD3) || (c == `PIO_CMD_RRA);
  endfunction

  // sense index tested by a skip command, valid flag in msb
  function automatic logic [2:0] skip_sel(input logic [`PIO_CMD_W-1:0] c);
    case (c)
      `PIO_CMD_SKP1: skip_sel = 3'h4;
      `PIO_CMD_SKP2: skip_sel = 3'h5;
      `PIO_CMD_SKP3: skip_sel = 3'h6;
      `PIO_CMD_SKP4: skip_sel = 3'h7;
      default:       skip_sel = 3'h0;
    endcase
  endfunction

  // all pins are asynchronous to i_clk
  pio_sync #(
    .W($bits(pio_pkg::pio_pins_t))
  ) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  ({i_io_strobe_n, i_first_transfer_phase, i_transfer_timing_phase,
                i_priority_enable_in, i_interrupt_grant_in, i_sense, i_select_id, i_shared_bus}),
    .o_sync   (s)
  );

  // edges of the processor strobes
  assign phase_rise  = s.phase & ~r.phase_d;
  assign strobe_fall = ~s.strobe_n & r.strobe_d;
  assign strobe_rise = s.strobe_n & ~r.strobe_d;
  assign vec_idx     = first_idx(r.sense & r.ie);

  // next state of the whole port
  always_comb begin
    logic [2:0] sk;
    sk         = skip_sel(r.cmd);
    n          = r;
    n.phase_d  = s.phase;
    n.strobe_d = s.strobe_n;
    // new requests only counted while grant is low; a serviced
    // request may still fall so a claimed element cannot claim twice
    if (!s.grant) begin
      n.irq_req = |(r.sense & r.ie);
    end else begin
      n.irq_req = r.irq_req & (|(r.sense & r.ie));
    end
    n.priority_chain_out = s.pri_in & ~r.irq_req;
    // type lines only during the first phase
    if (!s.phase) begin
      n.tt1_oe = 1'b0;
      n.tt2_oe = 1'b0;
    end
    case (r.phase)
      pio_pkg::PH_IDLE, pio_pkg::PH_DECODED: begin
        if (phase_rise) begin
          n.cmd   = s.bus[`PIO_CMD_HI:`PIO_CMD_LO];
          n.sel   = (s.sel_id == s.bus[`PIO_ID_HI:`PIO_ID_LO]) && (s.sel_id != `PIO_ID_NONE);
          n.claim = s.grant & s.pri_in & r.irq_req;
          if (s.grant & s.pri_in & r.irq_req) begin
            n.tt1_oe = 1'b1;
            n.tt2_oe = 1'b1;
          end else if ((s.sel_id == s.bus[`PIO_ID_HI:`PIO_ID_LO]) && (s.sel_id != `PIO_ID_NONE)
                       && is_read_kind(s.bus[`PIO_CMD_HI:`PIO_CMD_LO])) begin
            n.tt1_oe = 1'b1;
          end
          n.phase = pio_pkg::PH_DECODED;
        end else if (r.phase == pio_pkg::PH_DECODED && strobe_fall) begin
          n.phase = pio_pkg::PH_STROBE;
          if (r.claim) begin
            n.bus_out = {VECTOR_BASE, vec_idx};
            n.bus_oe  = 1'b1;
            n.sense[vec_idx] = 1'b0;
          end else if (r.sel) begin
            case (r.cmd)
              `PIO_CMD_RD1: n.rd1 = s.transfer_timing_phase;
              `PIO_CMD_RD2: n.rd2 = s.transfer_timing_phase;
              `PIO_CMD_RD3: n.rd3 = s.transfer_timing_phase;
              `PIO_CMD_WR1: n.wr1 = ~s.transfer_timing_phase;
              `PIO_CMD_WR2: n.wr2 = ~s.transfer_timing_phase;
              `PIO_CMD_RRA: begin
                n.bus_out = {{(`PIO_BUS_W - `PIO_SENSE_W){1'b0}}, r.ctrl_a};
                n.bus_oe  = s.transfer_timing_phase;
              end
              `PIO_CMD_WRA: begin
                if (!s.transfer_timing_phase) begin
                  n.ctrl_a = s.bus[`PIO_DATA_HI:`PIO_DATA_LO];
                end
              end
              `PIO_CMD_WIE: begin
                if (!s.transfer_timing_phase) begin
                  n.ie = s.bus[`PIO_DATA_HI:`PIO_DATA_LO];
                end
              end
              `PIO_CMD_SF1: n.ctrl_a[0] = 1'b1;
              `PIO_CMD_CF1: n.ctrl_a[0] = 1'b0;
              `PIO_CMD_SF3: n.ctrl_a[2] = 1'b1;
              `PIO_CMD_CF3: n.ctrl_a[2] = 1'b0;
              default: begin
                if (sk[2] && r.sense[sk[1:0]]) begin
                  n.skip_cmd        = 1'b1;
                  n.sense[sk[1:0]] = 1'b0;
                end
              end
            endcase
          end
        end else if (r.phase == pio_pkg::PH_DECODED && !s.phase && !r.sel && !r.claim) begin
          n.phase = pio_pkg::PH_IDLE;
        end
      end
      pio_pkg::PH_STROBE: begin
        if (strobe_rise) begin
          n.rd1      = 1'b0;
          n.rd2      = 1'b0;
          n.rd3      = 1'b0;
          n.wr1      = 1'b0;
          n.wr2      = 1'b0;
          n.bus_oe   = 1'b0;
          n.skip_cmd = 1'b0;
          n.sel      = 1'b0;
          n.claim    = 1'b0;
          n.phase    = pio_pkg::PH_IDLE;
        end
      end
      default: n.phase = pio_pkg::PH_IDLE;
    endcase
    // sense set wins over any clear this cycle
    n.sense   = n.sense | s.sense;
    n.skip_oe = n.skip_cmd | n.irq_req;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r        <= '0;
      r.ctrl_a <= `PIO_CTRL_A_RST;
      r.ie     <= `PIO_IE_RST;
      r.phase  <= pio_pkg::PH_IDLE;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state flops
  assign o_shared_bus_out            = r.bus_out;
  assign o_shared_bus_oe             = r.bus_oe;
  assign o_flag                      = r.ctrl_a;
  assign o_read_strobe_one           = r.rd1;
  assign o_read_strobe_two           = r.rd2;
  assign o_read_strobe_three         = r.rd3;
  assign o_write_strobe_one          = r.wr1;
  assign o_write_strobe_two          = r.wr2;
  assign o_transfer_type_line_one_oe = r.tt1_oe;
  assign o_transfer_type_line_two_oe = r.tt2_oe;
  assign o_skip_or_irq_line_oe       = r.skip_oe;
  assign o_priority_chain_out        = r.priority_chain_out;

  // checks on the port behaviour
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_flag_write: assert property (
    (r.phase == pio_pkg::PH_DECODED && strobe_fall && r.sel && !r.claim && r.cmd == `PIO_CMD_WRA && !s.transfer_timing_phase)
    |=> o_flag == $past(s.bus[`PIO_DATA_HI:`PIO_DATA_LO]))
    else $error("flags did not follow control register write");
  a_flag_direct: assert property (
    (r.phase == pio_pkg::PH_DECODED && strobe_fall && r.sel && !r.claim && r.cmd == `PIO_CMD_CF3)
    |=> !o_flag[2] && o_flag[3] == $past(o_flag[3]))
    else $error("flag three clear misbehaved");
  a_type_release: assert property (
    !s.phase |=> !o_transfer_type_line_one_oe && !o_transfer_type_line_two_oe)
    else $error("type lines driven outside first phase");
  a_type_vector: assert property (
    (phase_rise && s.grant && s.pri_in && r.irq_req) |=> o_transfer_type_line_one_oe && o_transfer_type_line_two_oe
    ##0 r.claim)
    else $error("vector claim not encoded");
  a_read_strobe: assert property (
    (r.phase == pio_pkg::PH_DECODED && strobe_fall && r.sel && !r.claim && r.cmd == `PIO_CMD_RD2 && s.transfer_timing_phase)
    |=> o_read_strobe_two ##1 (o_read_strobe_two || $past(strobe_rise)))
    else $error("read strobe two missing");
  a_write_strobe: assert property (
    $rose(o_write_strobe_one) |-> !$past(s.transfer_timing_phase) && r.cmd == `PIO_CMD_WR1)
    else $error("write strobe without write phase");
  a_bus_drive_own: assert property (
    o_shared_bus_oe |-> (r.claim || r.cmd == `PIO_CMD_RRA))
    else $error("bus driven for peripheral data");
  a_irq_pull: assert property (
    r.irq_req |-> o_skip_or_irq_line_oe)
    else $error("interrupt request not on skip line");
  a_grant_freeze: assert property (
    (s.grant && !r.irq_req) |=> !r.irq_req)
    else $error("request arose during grant");
  a_chain_low: assert property (
    (!s.pri_in || r.irq_req) |=> !o_priority_chain_out)
    else $error("priority out high while blocked");
  a_select_miss: assert property (
    (phase_rise && s.sel_id != s.bus[`PIO_ID_HI:`PIO_ID_LO]) |=> !r.sel)
    else $error("selected on wrong identity");
  // strobe, flag, skip, decode, vector and chain checks
  a_write_refused: assert property (
    (r.phase == pio_pkg::PH_DECODED && strobe_fall && r.sel && !r.claim && r.cmd == `PIO_CMD_WR1 && s.transfer_timing_phase)
    |=> !o_write_strobe_one)
    else $error("write strobe one during read timing");
  a_flag_set_one: assert property (
    (r.phase == pio_pkg::PH_DECODED && strobe_fall && r.sel && !r.claim && r.cmd == `PIO_CMD_SF1)
    |=> o_flag[0] && o_flag[3:1] == $past(o_flag[3:1]))
    else $error("flag one set misbehaved");
  a_rra_drive: assert property (
    (r.phase == pio_pkg::PH_DECODED && strobe_fall && r.sel && !r.claim && r.cmd == `PIO_CMD_RRA && s.transfer_timing_phase)
    |=> o_shared_bus_oe && o_shared_bus_out[`PIO_SENSE_W-1:0] == $past(o_flag))
    else $error("control register a not read back");
  a_vector_word: assert property (
    (r.phase == pio_pkg::PH_DECODED && strobe_fall && r.claim)
    |=> o_shared_bus_oe && o_shared_bus_out[`PIO_BUS_W-1:`PIO_BUS_W-`PIO_VEC_W] == VECTOR_BASE)
    else $error("vector word not driven on claim");
  a_skip_pull: assert property (
    (r.phase == pio_pkg::PH_DECODED && strobe_fall && r.sel && !r.claim && r.cmd == `PIO_CMD_SKP2 && r.sense[1])
    |=> o_skip_or_irq_line_oe)
    else $error("skip line not pulled on set sense");
  a_type_other: assert property (
    (phase_rise && r.phase != pio_pkg::PH_STROBE && !(s.grant && s.pri_in && r.irq_req)
     && s.sel_id != s.bus[`PIO_ID_HI:`PIO_ID_LO])
    |=> !o_transfer_type_line_one_oe && !o_transfer_type_line_two_oe)
    else $error("type lines pulled for unselected instruction");
  a_strobe_end: assert property (
    (r.phase == pio_pkg::PH_STROBE && strobe_rise)
    |=> !o_read_strobe_one && !o_read_strobe_two && !o_read_strobe_three
        && !o_write_strobe_one && !o_write_strobe_two && !o_shared_bus_oe)
    else $error("strobe outputs stand after io strobe rise");
  a_chain_high: assert property (
    (s.pri_in && !r.irq_req) |=> o_priority_chain_out)
    else $error("priority out low with no request pending");

  c_read: cover property (strobe_fall && r.sel ##1 o_read_strobe_one);
  c_write: cover property (strobe_fall && r.sel ##1 o_write_strobe_two);
  c_vector: cover property (r.claim && o_shared_bus_oe);
  c_skip: cover property (r.skip_cmd ##1 !r.skip_cmd);
  c_flag_three: cover property (strobe_fall && r.sel && r.cmd == `PIO_CMD_SF3);
endmodule

// ---- rtl/pio_consts.svh ----
// constants for the parallel i/o strobe and priority port
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH

// widths
`define PIO_BUS_W        12
`define PIO_ID_W         5
`define PIO_SENSE_W      4
`define PIO_CMD_W        4
`define PIO_VEC_W        10

// field positions on the shared bus (bus bit n of the word sits at index 11-n)
`define PIO_ID_HI        8
`define PIO_ID_LO        4
`define PIO_CMD_HI       3
`define PIO_CMD_LO       0
`define PIO_DATA_HI      3
`define PIO_DATA_LO      0

// reserved device identity
`define PIO_ID_NONE      5'h00

// command codes in bus bits 8-11
`define PIO_CMD_RD1      4'h0
`define PIO_CMD_WR1      4'h1
`define PIO_CMD_SKP1     4'h2
`define PIO_CMD_RRA      4'h3
`define PIO_CMD_RD2      4'h4
`define PIO_CMD_WR2      4'h5
`define PIO_CMD_SKP2     4'h6
`define PIO_CMD_WRA      4'h7
`define PIO_CMD_SF1      4'h8
`define PIO_CMD_CF1      4'h9
`define PIO_CMD_SKP3     4'ha
`define PIO_CMD_SF3      4'hb
`define PIO_CMD_CF3      4'hc
`define PIO_CMD_SKP4     4'hd
`define PIO_CMD_RD3      4'he
`define PIO_CMD_WIE      4'hf

// reset values
`define PIO_CTRL_A_RST   4'h0
`define PIO_IE_RST       4'h0
`define PIO_VEC_BASE_DEF 10'h000

`endif

// ---- rtl/pio_pkg.sv ----
// types shared by the parallel i/o port files
package pio_pkg;
  `include "pio_consts.svh"

  // pins after synchronising
  typedef struct packed {
    logic                        strobe_n;
    logic                        phase;
    logic                        transfer_timing_phase;
    logic                        pri_in;
    logic                        grant;
    logic [`PIO_SENSE_W-1:0]     sense;
    logic [`PIO_ID_W-1:0]        sel_id;
    logic [`PIO_BUS_W-1:0]       bus;
  } pio_pins_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_DECODED,
    PH_STROBE
  } pio_phase_t;

  // whole state of the port
  typedef struct packed {
    pio_phase_t                  phase;
    logic                        sel;
    logic                        claim;
    logic [`PIO_CMD_W-1:0]       cmd;
    logic [`PIO_SENSE_W-1:0]     ctrl_a;
    logic [`PIO_SENSE_W-1:0]     ie;
    logic [`PIO_SENSE_W-1:0]     sense;
    logic                        irq_req;
    logic                        phase_d;
    logic                        strobe_d;
    logic                        rd1;
    logic                        rd2;
    logic                        rd3;
    logic                        wr1;
    logic                        wr2;
    logic                        tt1_oe;
    logic                        tt2_oe;
    logic                        skip_cmd;
    logic                        skip_oe;
    logic                        priority_chain_out;
    logic                        bus_oe;
    logic [`PIO_BUS_W-1:0]       bus_out;
  } pio_state_t;
endpackage

// ---- rtl/pio_sync.sv ----
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pio_sync #(
  parameter int W = 1
) (
  input  wire logic          i_clk,
  input  wire logic          i_resetn,
  input  wire logic [W-1:0]  i_async,
  output logic [W-1:0]       o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } pio_sync_st_t;

  pio_sync_st_t r;
  pio_sync_st_t n;

  // first stage feeds only the second
  always_comb begin
    n      = r;
    n.meta = i_async;
    n.sync = r.meta;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_sync = r.sync;
endmodule

// ---- verif/pio_cpu_model.sv ----
// processor side model driving strobe, phase, timing and bus pins
`timescale 1ns/1ps
`include "pio_consts.svh"
module pio_cpu_model (
  input  wire logic                   i_clk,
  input  wire logic [`PIO_BUS_W-1:0]  i_dut_bus,
  input  wire logic                   i_dut_bus_oe,
  output logic                        o_io_strobe_n,
  output logic                        o_first_transfer_phase,
  output logic                        o_transfer_timing_phase,
  output logic [`PIO_BUS_W-1:0]       o_bus
);
  logic                   drv;
  logic [`PIO_BUS_W-1:0]  val;
  logic [`PIO_BUS_W-1:0]  last;

  // idle pin levels at time zero
  initial begin
    o_io_strobe_n = 1'b1;
    o_first_transfer_phase = 1'b0;
    o_transfer_timing_phase = 1'b1;
    drv = 1'b0;
    val = '0;
    last = '0;
  end

  // released bus shows a pattern that changes every cycle
  always @(posedge i_clk) last <= o_bus;
  assign o_bus = i_dut_bus_oe ? i_dut_bus : (drv ? val : ~last);

  // first phase with instruction word, held four cycles
  task automatic phase_go(input logic [`PIO_BUS_W-1:0] word);
    @(negedge i_clk);
    o_first_transfer_phase = 1'b1;
    drv = 1'b1;
    val = word;
    repeat (4) @(negedge i_clk);
  endtask

  // strobe low; write data only when timing is low
  task automatic strobe_go(input logic rd, input logic [3:0] data);
    o_first_transfer_phase = 1'b0;
    @(negedge i_clk);
    o_transfer_timing_phase = rd;
    o_io_strobe_n = 1'b0;
    drv = !rd;
    val = {8'h00, data};
    repeat (4) @(negedge i_clk);
  endtask

  // strobe high, then gap before next instruction
  task automatic strobe_end();
    o_io_strobe_n = 1'b1;
    drv = 1'b0;
    repeat (5) @(negedge i_clk);
  endtask
endmodule

// ---- verif/pio_port_bench.sv ----
// self-checking bench for the parallel i/o port
`timescale 1ns/1ps
`include "pio_consts.svh"
module pio_port_bench;
  localparam logic [9:0] VEC = 10'h2a5;
  localparam logic [4:0] ID  = 5'h0b;
  logic        clk, rstn, priority_enable_in, gnt;
  logic [3:0]  sense, flag;
  logic [4:0]  sel;
  logic        stb_n, ph, transfer_timing_phase, boe, r1, r2, r3, w1, w2, t1, t2, skoe, priority_chain_out;
  logic [11:0] bus, bout, bw;
  logic [1:0]  tt;
  logic [4:0]  st;
  logic        sk, bo;
  logic [3:0]  fexp;
  int          bad_count, compares;
  logic [3:0]  fc [5] = '{`PIO_CMD_WRA, `PIO_CMD_SF1, `PIO_CMD_CF3, `PIO_CMD_SF3, `PIO_CMD_CF1};
  logic [3:0]  fv [5] = '{4'he, 4'hf, 4'hb, 4'hf, 4'he};
  logic [3:0]  sc [7] = '{4'h0, 4'h4, 4'he, 4'h1, 4'h5, 4'h0, 4'h1};
  logic        sx [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [4:0]  se [7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00, 5'h00};
  logic [1:0]  te [7] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0};

  pio_port #(.VECTOR_BASE(VEC)) i_pio_port (.i_clk(clk), .i_resetn(rstn), .i_io_strobe_n(stb_n),
    .i_first_transfer_phase(ph), .i_transfer_timing_phase(transfer_timing_phase), .i_priority_enable_in(priority_enable_in),
    .i_interrupt_grant_in(gnt), .i_sense(sense), .i_select_id(sel), .i_shared_bus(bus),
    .o_shared_bus_out(bout), .o_shared_bus_oe(boe), .o_flag(flag), .o_read_strobe_one(r1),
    .o_read_strobe_two(r2), .o_read_strobe_three(r3), .o_write_strobe_one(w1), .o_write_strobe_two(w2),
    .o_transfer_type_line_one_oe(t1), .o_transfer_type_line_two_oe(t2), .o_skip_or_irq_line_oe(skoe),
    .o_priority_chain_out(priority_chain_out));
  pio_cpu_model i_pio_cpu_model (.i_clk(clk), .i_dut_bus(bout), .i_dut_bus_oe(boe), .o_io_strobe_n(stb_n),
    .o_first_transfer_phase(ph), .o_transfer_timing_phase(transfer_timing_phase), .o_bus(bus));

  // clock of 5 ns period
  always #2.5 clk = ~clk;

  // compare and count
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one whole i/o instruction, outputs captured while they stand
  task automatic io(input logic [3:0] cmd, input logic [4:0] id, input logic rd, input logic [3:0] d);
    i_pio_cpu_model.phase_go({3'h6, id, cmd});
    tt = {t2, t1};
    i_pio_cpu_model.strobe_go(rd, d);
    st = {w2, w1, r3, r2, r1};
    sk = skoe;
    bo = boe;
    bw = bout;
    i_pio_cpu_model.strobe_end();
  endtask

  // sense pin pulse, then settle
  task automatic pulse(input int i);
    sense[i] = 1'b1;
    repeat (4) @(negedge clk);
    sense[i] = 1'b0;
    repeat (5) @(negedge clk);
  endtask

  initial begin
    #100000;
    bad_count++;
    conclude();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    priority_enable_in = 1'b1; // upper neighbour's chain output, idle
    gnt = 1'b0;
    sense = 4'h0;
    sel = ID;
    bad_count = 0;
    compares = 0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (5) @(negedge clk);
    chk(12'(flag), 12'h000);
    chk(12'(priority_chain_out), 12'h001);
    $display("test reset done");
    // strobe commands, wrong timing refused
    for (int k = 0; k < 7; k++) begin
      io(sc[k], ID, sx[k], 4'h0);
      chk(12'(st), 12'(se[k]));
      chk(12'(bo), 12'h000);
      chk(12'(tt), 12'(te[k]));
    end
    io(`PIO_CMD_RD1, ID + 5'h01, 1'b1, 4'h0);
    chk(12'({tt, st}), 12'h000);
    sel = `PIO_ID_NONE;
    io(`PIO_CMD_RD1, `PIO_ID_NONE, 1'b1, 4'h0);
    chk(12'({tt, st}), 12'h000);
    sel = ID;
    $display("test strobes done");
    // flag writes and single bit commands
    for (int k = 0; k < 5; k++) begin
      io(fc[k], ID, 1'b0, (k == 0) ? fv[k] : ~fv[k]);
      chk(12'(flag), 12'(fv[k]));
    end
    fexp = fv[4];
    io(`PIO_CMD_RRA, ID, 1'b1, 4'h0);
    chk(12'({tt, bo}), 12'h003);
    chk(bw, {8'h00, fexp});
    $display("test flags done");
    // skip on set sense, cleared after use
    pulse(1);
    io(`PIO_CMD_SKP2, ID, 1'b1, 4'h0);
    chk(12'(sk), 12'h001);
    io(`PIO_CMD_SKP2, ID, 1'b1, 4'h0);
    chk(12'(sk), 12'h000);
    io(`PIO_CMD_SKP1, ID, 1'b1, 4'h0);
    chk(12'(sk), 12'h000);
    $display("test skip done");
    // interrupt request, chain and vector claim
    io(`PIO_CMD_WIE, ID, 1'b0, 4'h1);
    pulse(2);
    chk(12'({skoe, priority_chain_out}), 12'h001);
    pulse(0);
    chk(12'({skoe, priority_chain_out}), 12'h002);
    gnt = 1'b1;
    repeat (5) @(negedge clk);
    io(`PIO_CMD_RD1, 5'h11, 1'b1, 4'h0);
    chk(12'({tt, bo, st}), 12'h0e0);
    chk(bw, {VEC, 2'h0});
    pulse(0);
    chk(12'({skoe, priority_chain_out}), 12'h001);
    gnt = 1'b0;
    repeat (5) @(negedge clk);
    chk(12'({skoe, priority_chain_out}), 12'h002);
    priority_enable_in = 1'b0;
    gnt = 1'b1;
    repeat (5) @(negedge clk);
    chk(12'(priority_chain_out), 12'h000);
    io(`PIO_CMD_RD1, 5'h11, 1'b1, 4'h0);
    chk(12'({tt, bo}), 12'h000);
    $display("test interrupt done");
    conclude();
  end
endmodule
